// *** acp_ctrl.sv ***
`timescale 1ns/1ps
module acp_ctrl (
    input  wire logic ref_clk,                        // 50 MHz system clock
    input  wire logic nrst,                           // Device reset pin, active low
    input  wire logic sclk,                           // Serial clock from host
    input  wire logic cs_n,                           // Chip select, active low
    input  wire logic din,                            // Serial data in
    output logic      dout,                           // Serial data out
    output logic      dout_oe_n,                      // Data out enable, low drives
    input  wire logic master_clock_input,             // External master clock
    output logic      master_clock_output,            // Inverted clock or low
    output logic      analog_common_or_port_zero_out, // Port zero driven level
    output logic      analog_common_or_port_zero_oe_n,// Low while driving port zero
    output logic      analog_common_select,           // Pin serves as analog common
    input  wire logic sync_or_port_one_in,            // Port one pin level
    output logic      sync_or_port_one_out,           // Port one driven level
    output logic      sync_or_port_one_oe_n,          // Low while driving port one
    output logic      modulator_sync                  // Pulse restarting modulator and filter
);

    logic                   sclk_s;
    logic                   cs_n_s;
    logic                   din_s;
    logic                   p1_s;
    logic                   sclk_d_reg;
    logic                   sclk_rise;
    logic                   sclk_fall;
    logic                   p1_d_reg;
    acp_pkg::acp_state_t    state_reg,  state_next;
    logic [2:0]             cnt_reg,    cnt_next;
    logic [7:0]             shin_reg,   shin_next;
    logic [7:0]             shout_reg,  shout_next;
    logic                   dout_reg,   dout_next;
    logic                   rd_reg,     rd_next;
    logic [2:0]             addr_reg,   addr_next;
    logic                   sync_reg,   sync_next;
    logic [7:0]             regs_reg  [acp_pkg::NUM_REGS];
    logic [7:0]             regs_next [acp_pkg::NUM_REGS];
    logic [7:0]             byte_in;
    logic [7:0]             rd_val;
    logic                   byte_done;
    acp_pkg::acp_port_t     port_r;
    acp_pkg::acp_mode_t     mode_r;

    acp_sync #(
        .WIDTH (4)
    ) u_sync (
        .ref_clk  (ref_clk),
        .nrst     (nrst),
        .async_in ({sclk, cs_n, din, sync_or_port_one_in}),
        .sync_out ({sclk_s, cs_n_s, din_s, p1_s})
    );

    assign port_r    = acp_pkg::acp_port_t'(regs_reg[acp_pkg::ADDR_PORT]);
    assign mode_r    = acp_pkg::acp_mode_t'(regs_reg[acp_pkg::ADDR_MODE]);
    // Host clock edges seen from the synchronised copy only
    assign sclk_rise = sclk_s & ~sclk_d_reg;
    assign sclk_fall = ~sclk_s & sclk_d_reg;
    assign byte_in   = {shin_reg[6:0], din_s};
    assign byte_done = sclk_rise && !cs_n_s && (cnt_reg == acp_pkg::BIT_LAST);

    // Clock buffer is pure logic on the pin, untouched by reset
    assign master_clock_output = mode_r.clk_dis ? 1'b0 : ~master_clock_input;

    assign analog_common_or_port_zero_out  = port_r.p0_val;
    assign analog_common_or_port_zero_oe_n = port_r.port_zero_direction_bit;
    assign analog_common_select            = port_r.port_zero_direction_bit;
    assign sync_or_port_one_out            = port_r.p1_val;
    assign sync_or_port_one_oe_n           = port_r.port_one_direction_bit;

    assign dout      = dout_reg;
    assign dout_oe_n = !(state_reg == acp_pkg::ST_DATA && rd_reg && !cs_n_s);
    assign modulator_sync = sync_reg;

    // Port register reads back the port one pin itself while it is an input
    always_comb begin
        rd_val = regs_reg[addr_next];
        if (addr_next == acp_pkg::ADDR_PORT && port_r.port_one_direction_bit) begin
            rd_val[1] = p1_s;
        end
    end

    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        shin_next  = shin_reg;
        shout_next = shout_reg;
        dout_next  = dout_reg;
        rd_next    = rd_reg;
        addr_next  = addr_reg;
        for (int i = 0; i < acp_pkg::NUM_REGS; i++) begin
            regs_next[i] = regs_reg[i];
        end
        if (cs_n_s) begin
            // Deselect drops any partial byte
            cnt_next = acp_pkg::BIT_FIRST;
        end else if (sclk_rise) begin
            shin_next = byte_in;
            cnt_next  = cnt_reg + 3'h1;
            if (byte_done) begin
                unique case (state_reg)
                    acp_pkg::ST_COMM: begin
                        rd_next    = byte_in[acp_pkg::COMM_RW_POS];
                        addr_next  = byte_in[acp_pkg::ADDR_W-1:0];
                        state_next = acp_pkg::ST_DATA;
                    end
                    acp_pkg::ST_DATA: begin
                        if (!rd_reg) begin
                            regs_next[addr_reg] = byte_in;
                        end
                        state_next = acp_pkg::ST_COMM;
                    end
                endcase
            end
        end else if (sclk_fall && state_reg == acp_pkg::ST_DATA && rd_reg) begin
            dout_next  = shout_reg[7];
            shout_next = {shout_reg[6:0], 1'b0};
        end
        // Read data loads as the command byte completes
        if (byte_done && state_reg == acp_pkg::ST_COMM) begin
            shout_next = rd_val;
        end
    end

    always_comb begin
        sync_next = 1'b0;
        if (port_r.sync_en && port_r.port_one_direction_bit && p1_d_reg && !p1_s) begin
            sync_next = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg  <= acp_pkg::ST_COMM;
            cnt_reg    <= acp_pkg::BIT_FIRST;
            shin_reg   <= acp_pkg::GEN_RST;
            shout_reg  <= acp_pkg::GEN_RST;
            dout_reg   <= 1'b0;
            rd_reg     <= 1'b0;
            addr_reg   <= '0;
            sclk_d_reg <= 1'b1;
            p1_d_reg   <= 1'b1;
            sync_reg   <= 1'b0;
            for (int i = 0; i < acp_pkg::NUM_REGS; i++) begin
                regs_reg[i] <= acp_pkg::GEN_RST;
            end
            regs_reg[acp_pkg::ADDR_PORT] <= acp_pkg::PORT_RST;
            regs_reg[acp_pkg::ADDR_MODE] <= acp_pkg::MODE_RST;
        end else begin
            state_reg  <= state_next;
            cnt_reg    <= cnt_next;
            shin_reg   <= shin_next;
            shout_reg  <= shout_next;
            dout_reg   <= dout_next;
            rd_reg     <= rd_next;
            addr_reg   <= addr_next;
            sclk_d_reg <= sclk_s;
            p1_d_reg   <= p1_s;
            sync_reg   <= sync_next;
            for (int i = 0; i < acp_pkg::NUM_REGS; i++) begin
                regs_reg[i] <= regs_next[i];
            end
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    a_mclk_invert: assert property (!mode_r.clk_dis |-> master_clock_output == ~master_clock_input)
        else $error("master clock output not inverted input");
    a_mclk_off: assert property (mode_r.clk_dis |-> !master_clock_output)
        else $error("master clock output active while disabled");
    a_mclk_reset: assert property (disable iff (1'b0)
        (!nrst && !mode_r.clk_dis) |-> master_clock_output == ~master_clock_input)
        else $error("clock output stopped by reset");
    a_cs_idle: assert property (cs_n_s |-> dout_oe_n ##1 cnt_reg == acp_pkg::BIT_FIRST)
        else $error("interface active while deselected");
    a_byte_frame: assert property (byte_done |=> cnt_reg == acp_pkg::BIT_FIRST && state_reg != $past(state_reg))
        else $error("byte did not close after eight bits");
    a_count_step: assert property ((sclk_rise && !cs_n_s) |=> cnt_reg == $past(cnt_reg) + 3'h1)
        else $error("bit count did not advance");
    a_reset_idle: assert property (disable iff (1'b0) $rose(nrst) |-> state_reg == acp_pkg::ST_COMM && cnt_reg == 3'h0)
        else $error("interface not idle after reset");
    a_port_zero: assert property (analog_common_or_port_zero_oe_n == port_r.port_zero_direction_bit
        && analog_common_or_port_zero_out == port_r.p0_val)
        else $error("port zero pin mismatch");
    a_port_one: assert property (sync_or_port_one_oe_n == port_r.port_one_direction_bit)
        else $error("port one direction mismatch");
    a_sync_pulse: assert property ((port_r.sync_en && port_r.port_one_direction_bit && p1_d_reg && !p1_s) |=> modulator_sync)
        else $error("sync pulse missing");
    a_reg_write: assert property ((byte_done && state_reg == acp_pkg::ST_DATA && !rd_reg)
        |=> regs_reg[$past(addr_reg)] == $past(byte_in))
        else $error("written byte not stored at address");

endmodule

// *** acp_host.sv ***
`timescale 1ns/1ps
module acp_host (
    input  wire logic        ref_clk, // System clock
    input  wire logic        sdo,     // Data line from device
    output logic             sclk,    // Serial clock, idles high
    output logic             cs_n,    // Select, active low
    output logic             din,     // Data to device
    output logic [7:0]       rd_byte, // Last read data byte
    output logic [15:0]      rd_cnt   // Bumps on each read byte
);
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        din = 1'b0;
        rd_byte = 8'h00;
        rd_cnt = 16'h0000;
    end
    // Mode 0 keeps select low, 1 frames each byte, 2 leaves device deselected
    task automatic byte_io(input logic [7:0] b, input int md, output logic [7:0] r);
        for (int i = 7; i >= 0; i--) begin
            @(negedge ref_clk);
            cs_n = (md == 2);
            sclk = 1'b0;
            din = b[i];
            repeat (4) @(negedge ref_clk);
            // Take each bit just before the rising edge, while the device still drives it
            r[i] = sdo;
            sclk = 1'b1;
            repeat (3) @(negedge ref_clk);
        end
        @(negedge ref_clk);
        din = ~din;
        if (md == 1)
            cs_n = 1'b1;
    endtask
    task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, input int md);
        logic [7:0] r;
        byte_io(cmd, md, r);
        byte_io(wd, md, r);
        if (cmd[6] && md != 2) begin
            rd_byte = r;
            rd_cnt = rd_cnt + 16'h0001;
        end
    endtask
    task automatic partial(input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge ref_clk);
            cs_n = 1'b0;
            sclk = 1'b0;
            repeat (4) @(negedge ref_clk);
            sclk = 1'b1;
            repeat (3) @(negedge ref_clk);
        end
        @(negedge ref_clk);
        cs_n = 1'b1;
    endtask
endmodule

// *** acp_pkg.sv ***
package acp_pkg;

    localparam int          ADDR_W        = 3;
    localparam int          NUM_REGS      = 8;
    localparam int          BYTE_BITS     = 8;
    localparam logic [2:0]  BIT_LAST      = 3'h7;
    localparam logic [2:0]  BIT_FIRST     = 3'h0;

    // Register indices reached through the communications address bits
    localparam logic [2:0]  ADDR_PORT     = 3'h1;
    localparam logic [2:0]  ADDR_MODE     = 3'h2;

    // Values after reset
    localparam logic [7:0]  PORT_RST      = 8'h30;
    localparam logic [7:0]  MODE_RST      = 8'h00;
    localparam logic [7:0]  GEN_RST       = 8'h00;

    // Field positions in the communications byte
    localparam int          COMM_RW_POS   = 6;

    typedef struct packed {
        logic [1:0] rsv_hi;
        logic       port_one_direction_bit;
        logic       port_zero_direction_bit;
        logic       sync_en;
        logic       rsv_lo;
        logic       p1_val;
        logic       p0_val;
    } acp_port_t;

    typedef struct packed {
        logic [3:0] rsv_hi;
        logic       clk_dis;
        logic [2:0] rsv_lo;
    } acp_mode_t;

    typedef enum logic [1:0] {
        ST_COMM = 2'b00,
        ST_DATA = 2'b01
    } acp_state_t;

endpackage

// *** acp_sync.sv ***
`timescale 1ns/1ps
module acp_sync #(
    parameter int WIDTH = 4
) (
    input  wire logic             ref_clk,  // System clock
    input  wire logic             nrst,     // Async reset, active low
    input  wire logic [WIDTH-1:0] async_in, // Pins from outside the domain
    output logic      [WIDTH-1:0] sync_out  // Two-flop synchronised copy
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    initial begin
        if (WIDTH < 1) begin
            $error("acp_sync width must be positive");
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            meta_reg <= '1;
            sync_reg <= '1;
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;

endmodule

// *** tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
    logic        ref_clk, nrst, mclk_in, mclk_out, p1_in, dout, dout_oe_n, dout_last;
    logic        p0_out, p0_oe_n, ac_sel, p1_out, p1_oe_n, msync, sclk, cs_n, din;
    logic [7:0]  rd_byte, mem[8], exp_q[$];
    logic [15:0] rd_cnt;
    logic [31:0] seed = 32'h5C283F82;
    int          error_cnt = 0, n_compared = 0, cyc = 0, syncs = 0, n;
    wire         sdo = dout_oe_n ? ~dout_last : dout;
    wire [7:0]   pins = {3'h0, p1_oe_n, p1_out, ac_sel, p0_oe_n, p0_out};

    acp_ctrl dut_u (.ref_clk(ref_clk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .din(din),
        .dout(dout), .dout_oe_n(dout_oe_n), .master_clock_input(mclk_in),
        .master_clock_output(mclk_out), .analog_common_or_port_zero_out(p0_out),
        .analog_common_or_port_zero_oe_n(p0_oe_n), .analog_common_select(ac_sel),
        .sync_or_port_one_in(p1_in), .sync_or_port_one_out(p1_out),
        .sync_or_port_one_oe_n(p1_oe_n), .modulator_sync(msync));
    acp_host host_u (.ref_clk(ref_clk), .sdo(sdo), .sclk(sclk), .cs_n(cs_n), .din(din),
        .rd_byte(rd_byte), .rd_cnt(rd_cnt));

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    always begin
        repeat (3) @(negedge ref_clk);
        mclk_in = ~mclk_in;
    end
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        syncs <= syncs + int'(msync);
        if (!dout_oe_n)
            dout_last <= dout;
        if (cyc == 30000) begin
            error_cnt++;
            stop_test();
        end
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    always @(rd_cnt)
        if (exp_q.size() > 0)
            check(exp_q.pop_front(), rd_byte);
    task automatic chk_clk(input logic en);
        #2;
        check({7'h00, ~mclk_in & en}, {7'h00, mclk_out});
    endtask
    // Upper command bits other than the read flag are random and must be ignored
    task automatic wr(input logic [2:0] a, input logic [7:0] d, input int md);
        void'(xs());
        host_u.xfer({seed[7], 1'b0, seed[5:3], a}, d, md);
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] e, input int md);
        void'(xs());
        exp_q.push_back(e);
        host_u.xfer({seed[7], 1'b1, seed[5:3], a}, seed[15:8], md);
    endtask
    task automatic stop_test();
        $display("Compared %0d, errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        nrst = 1'b0;
        mclk_in = 1'b0;
        p1_in = 1'b0;
        dout_last = 1'b0;
        repeat (20) @(negedge ref_clk);
        chk_clk(1'b1);
        nrst = 1'b1;
        check(8'h16, pins);
        repeat (5) @(negedge ref_clk);
        rd(acp_pkg::ADDR_PORT, acp_pkg::PORT_RST, 0);
        $display("Test reset done");
        for (int md = 0; md < 2; md++) begin
            for (int a = 0; a < 8; a++) begin
                void'(xs());
                mem[a] = (a == 1) ? {6'h00, seed[1:0]} : (a == 2) ? {4'h0, seed[3], 3'h0} : seed[7:0];
                wr(a[2:0], mem[a], md);
            end
            repeat (4) @(negedge ref_clk);
            check({4'h0, mem[1][1], 2'h0, mem[1][0]}, pins);
            chk_clk(~mem[2][3]);
            for (int a = 0; a < 8; a++)
                rd(a[2:0], mem[a], md);
        end
        $display("Test registers done");
        wr(3'h3, ~mem[3], 2);
        host_u.partial(5);
        rd(3'h3, mem[3], 0);
        wr(acp_pkg::ADDR_MODE, 8'h08, 1);
        chk_clk(1'b0);
        wr(acp_pkg::ADDR_MODE, 8'h00, 0);
        chk_clk(1'b1);
        $display("Test select and clock done");
        wr(acp_pkg::ADDR_PORT, 8'h38, 0);
        p1_in = 1'b1;
        repeat (6) @(negedge ref_clk);
        rd(acp_pkg::ADDR_PORT, 8'h3A, 0);
        n = syncs;
        p1_in = 1'b0;
        repeat (8) @(negedge ref_clk);
        check(8'(n + 1), 8'(syncs));
        wr(acp_pkg::ADDR_PORT, 8'h30, 1);
        p1_in = 1'b1;
        repeat (6) @(negedge ref_clk);
        p1_in = 1'b0;
        repeat (8) @(negedge ref_clk);
        check(8'(n + 1), 8'(syncs));
        $display("Test sync done");
        wr(3'h3, 8'hA5, 0);
        nrst = 1'b0;
        repeat (10) @(negedge ref_clk);
        chk_clk(1'b1);
        nrst = 1'b1;
        repeat (5) @(negedge ref_clk);
        rd(3'h3, acp_pkg::GEN_RST, 0);
        rd(acp_pkg::ADDR_PORT, acp_pkg::PORT_RST, 0);
        $display("Test mid reset done");
        repeat (10) @(negedge ref_clk);
        stop_test();
    end
endmodule
